// ### pirc_core_model.sv
// Core model: follows vector loads, returns from handlers on request.
// Assumes core outputs are one-cycle register pulses.
`timescale 1ns/100ps
module pirc_core_model
   import pirc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Controller side
   input wire pirc_core_s core,
   input wire logic ret_req,
   output logic handler_return
);
   int depth;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         depth <= 0;
         handler_return <= 1'b0;
      end else begin
         // Only return from a handler really entered
         handler_return <= ret_req && depth > 0;
         if (core.restart)
            depth <= 0;
         else if (core.stack_push)
            depth <= depth + 1;
         else if (handler_return)
            depth <= depth - 1;
      end
   end
endmodule : pirc_core_model

// ### pirc_ctrl.sv
// Two-level interrupt controller with reset-cause flags, AHB-Lite slave.
// Assumes the core follows pc_load/stack_push and pulses handler_return on a return.
//
// Notes on behaviour
// R1 - High vector 000008h, low vector 000018h
// R2 - High preempts low; low waits during high
// R3 - Each source: flag, enable, priority bit
// R4 - Priority levels only when enable bit set
// R5 - Priority mode: high and low global gates
// R6 - Vector when flag, enable, global enable set
// R7 - Compatibility mode ignores priority bits
// R8 - Compatibility: peripheral gate, global gate
// R9 - Compatibility mode uses vector 000008h only
// R10 - Taking interrupt clears governing global enable
// R11 - Taking interrupt pushes return, loads vector
// R12 - Handler clears flags before re-enabling
// R13 - Return sets governing global enable again
// R14 - External event to vector: three cycles
// R15 - Flags set regardless of any enable
// R16 - Wake clears sleep flag, vectors if enabled
// R17 - Master clear in run: restart, set timeout
// R18 - Master clear idle/sleep: also clear sleep
// R19 - Watchdog in run: restart, clear timeout
// R20 - Watchdog idle/sleep: wake, clear both flags
// R21 - Overflow with reset enable: flag, restart
// R22 - Underflow without reset enable: flag only
`timescale 1ns/100ps
module pirc_ctrl
   import pirc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Interrupt sources, one-cycle event pulses
   input wire logic [NSRC-1:0] src_event,
   // Core state and events
   input wire pirc_pm_e pm_mode,
   input wire pirc_rst_ev_s rst_ev,
   input wire logic handler_return,
   // Core control
   output pirc_core_s core,
   output logic in_high,
   output logic in_low
);

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic rdy;
      logic [7:0] ctl;
      logic [7:0] rcc;
      logic [NSRC-1:0] flag;
      logic [NSRC-1:0] en;
      logic [NSRC-1:0] pri;
      logic [2:0] stk;
      logic req_hi;
      logic req_lo;
      logic in_high;
      logic in_low;
      pirc_core_s core;
   } pirc_state_s;

   pirc_state_s s;
   pirc_state_s next_s;

   logic [NSRC-1:0] act;
   logic compat;
   logic low_power;
   logic hi_now;
   logic lo_now;
   logic bus_ok;

   function automatic logic [31:0] pirc_read(input logic [7:0] a, input pirc_state_s st);
      logic [31:0] d;
      d = 32'h00000000;
      if (a == OFS_IRQ_CTL) begin
         d[7:0] = st.ctl;
      end else if (a == OFS_RCC) begin
         d[7:0] = st.rcc;
      end else if (a == OFS_FLAG) begin
         d[NSRC-1:0] = st.flag;
      end else if (a == OFS_EN) begin
         d[NSRC-1:0] = st.en;
      end else if (a == OFS_PRI) begin
         d[NSRC-1:0] = st.pri;
      end else if (a == OFS_STK) begin
         d[2:0] = st.stk;
      end
      return d;
   endfunction : pirc_read

   always_comb begin
      next_s = s;
      next_s.core.pc_load = 1'b0;
      next_s.core.stack_push = 1'b0;
      next_s.core.wake = 1'b0;
      next_s.core.restart = 1'b0;
      next_s.rdy = 1'b1;

      // Only whole-word transfers in the low window decode
      bus_ok = hsel & hready & htrans[1] & (hsize == 3'b010) & (haddr[31:8] == 24'h000000);

      // Data phase of a write; unmapped offsets fall through silently
      if (s.wr_pend) begin
         if (s.wr_addr == OFS_IRQ_CTL) begin
            next_s.ctl = hwdata[7:0] & CTL_WMASK;
         end else if (s.wr_addr == OFS_RCC) begin
            next_s.rcc = (s.rcc & ~RCC_WMASK) | (hwdata[7:0] & RCC_WMASK); // [R4]
         end else if (s.wr_addr == OFS_FLAG) begin
            next_s.flag = hwdata[NSRC-1:0]; // [R3] [R12]
         end else if (s.wr_addr == OFS_EN) begin
            next_s.en = hwdata[NSRC-1:0]; // [R3]
         end else if (s.wr_addr == OFS_PRI) begin
            next_s.pri = hwdata[NSRC-1:0]; // [R3]
         end else if (s.wr_addr == OFS_STK) begin
            next_s.stk = hwdata[2:0];
         end
      end
      next_s.wr_pend = bus_ok & hwrite;
      next_s.wr_addr = haddr[7:0];

      // Events win over a software clear in the same cycle
      next_s.flag = next_s.flag | src_event; // [R15]

      // Handler return restores the enable of the level left
      if (handler_return) begin
         if (s.in_high) begin
            next_s.in_high = 1'b0;
            next_s.ctl[CTL_HIGH_GE] = 1'b1; // [R13]
         end else if (s.in_low) begin
            next_s.in_low = 1'b0;
            next_s.ctl[CTL_LOW_GE] = 1'b1; // [R13]
         end else begin
            next_s.ctl[CTL_HIGH_GE] = 1'b1; // [R13]
         end
      end

      // Arbitration
      act = s.flag & s.en; // [R6]
      compat = ~s.rcc[RCC_PRIO_EN]; // [R4]
      low_power = (pm_mode == PM_IDLE) || (pm_mode == PM_SLEEP);
      if (compat) begin
         // Priority bits ignored; peripheral sources need the second gate
         hi_now = s.ctl[CTL_HIGH_GE] & (|(act & (~SRC_PERIPH_MASK | (s.ctl[CTL_LOW_GE] ? SRC_PERIPH_MASK : 8'h00)))); // [R7] [R8]
         lo_now = 1'b0; // [R9]
      end else begin
         hi_now = s.ctl[CTL_HIGH_GE] & (|(act & s.pri)); // [R5]
         lo_now = s.ctl[CTL_LOW_GE] & (|(act & ~s.pri)) & ~s.in_high; // [R5] [R2]
      end

      // One pipeline stage keeps latency at three cycles from event
      next_s.req_hi = hi_now; // [R14]
      next_s.req_lo = lo_now; // [R14]

      // Re-checking the live enable blocks a second take off a stale request
      if (s.req_hi & hi_now) begin
         next_s.ctl[CTL_HIGH_GE] = 1'b0; // [R10]
         next_s.in_high = 1'b1; // [R2]
         next_s.core.pc_load = 1'b1; // [R11]
         next_s.core.stack_push = 1'b1; // [R11]
         next_s.core.pc_value = VEC_HIGH; // [R1] [R9]
         next_s.req_hi = 1'b0;
         next_s.req_lo = 1'b0;
      end else if (s.req_lo & lo_now) begin
         next_s.ctl[CTL_LOW_GE] = 1'b0; // [R10]
         next_s.in_low = 1'b1;
         next_s.core.pc_load = 1'b1; // [R11]
         next_s.core.stack_push = 1'b1; // [R11]
         next_s.core.pc_value = VEC_LOW; // [R1]
         next_s.req_lo = 1'b0;
      end

      // Interrupt wake needs only flag and enable; the vector follows if gated in
      if (low_power && (|act)) begin
         next_s.core.wake = 1'b1; // [R16]
         next_s.rcc[RCC_SLEEP] = 1'b0; // [R16]
      end

      if (rst_ev.sleep_instr) begin
         next_s.rcc[RCC_WDT_TO] = 1'b1;
         next_s.rcc[RCC_SLEEP] = 1'b0;
      end

      if (rst_ev.wdt_timeout) begin
         next_s.rcc[RCC_WDT_TO] = 1'b0; // [R19] [R20]
         if (low_power) begin
            next_s.rcc[RCC_SLEEP] = 1'b0; // [R20]
            next_s.core.wake = 1'b1; // [R20]
         end else begin
            next_s.core.restart = 1'b1; // [R19]
         end
      end

      if (rst_ev.master_clear_input) begin
         next_s.rcc[RCC_WDT_TO] = 1'b1; // [R17] [R18]
         if (low_power) begin
            next_s.rcc[RCC_SLEEP] = 1'b0; // [R18]
         end
         next_s.core.restart = 1'b1; // [R17] [R18]
      end

      if (rst_ev.stack_overflow) begin
         next_s.stk[STK_OVF] = 1'b1; // [R21]
         if (s.stk[STK_RST_EN]) begin
            next_s.core.restart = 1'b1; // [R21]
         end
      end

      if (rst_ev.stack_underflow) begin
         next_s.stk[STK_UNF] = 1'b1; // [R22]
         if (s.stk[STK_RST_EN]) begin
            next_s.core.restart = 1'b1;
         end
      end

      if (rst_ev.reset_instr) begin
         next_s.rcc[RCC_SOFT_RST] = 1'b0;
         next_s.core.restart = 1'b1;
      end

      if (rst_ev.brownout) begin
         next_s.rcc[RCC_SOFT_RST] = 1'b1;
         next_s.rcc[RCC_WDT_TO] = 1'b1;
         next_s.rcc[RCC_SLEEP] = 1'b1;
         next_s.rcc[RCC_BROWNOUT] = 1'b0;
         next_s.core.restart = 1'b1;
      end

      // A restart overrides any vector in flight and ends both handlers
      if (next_s.core.restart) begin
         next_s.core.pc_load = 1'b1; // [R17] [R19] [R21]
         next_s.core.pc_value = VEC_RESTART;
         next_s.core.stack_push = 1'b0;
         next_s.core.wake = 1'b0;
         next_s.in_high = 1'b0;
         next_s.in_low = 1'b0;
         next_s.req_hi = 1'b0;
         next_s.req_lo = 1'b0;
      end

      // Read data from the next state so a read right after a write sees it
      if (bus_ok & ~hwrite) begin
         next_s.rdata = pirc_read(haddr[7:0], next_s);
      end else begin
         next_s.rdata = 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s.wr_pend <= 1'b0;
         s.wr_addr <= 8'h00;
         s.rdata <= 32'h00000000;
         s.rdy <= 1'b1;
         s.ctl <= CTL_RST;
         s.rcc <= RCC_RST; // [R4]
         s.flag <= '0;
         s.en <= '0;
         s.pri <= '0;
         s.stk <= STK_RST;
         s.req_hi <= 1'b0;
         s.req_lo <= 1'b0;
         s.in_high <= 1'b0;
         s.in_low <= 1'b0;
         s.core <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.rdata;
   assign hreadyout = s.rdy;
   assign hresp = 1'b0;
   assign core = s.core;
   assign in_high = s.in_high;
   assign in_low = s.in_low;

endmodule : pirc_ctrl

// ### pirc_ctrl_assertions.sv
// Port checker for the interrupt and reset-cause controller.
// Assumes one hclk domain; bound to pirc_ctrl below.
`timescale 1ns/100ps
module pirc_ctrl_assertions
   import pirc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Core side
   input wire pirc_pm_e pm_mode,
   input wire pirc_rst_ev_s rst_ev,
   input wire logic handler_return,
   input wire pirc_core_s core,
   input wire logic in_high,
   input wire logic in_low
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_restart;
      core.restart && core.pc_load && core.pc_value == VEC_RESTART;
   endsequence
   sequence s_vector;
      core.pc_load && !core.restart;
   endsequence
   property p_vec_addr;
      s_vector |-> core.pc_value == VEC_HIGH || core.pc_value == VEC_LOW;
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("bad vector address");
   property p_push;
      s_vector |-> core.stack_push;
   endproperty
   a_push: assert property (p_push) else $error("vector without push");
   property p_master_clear_input;
      rst_ev.master_clear_input |=> s_restart;
   endproperty
   a_master_clear_input: assert property (p_master_clear_input) else $error("no restart on master clear");
   property p_wdt_run;
      rst_ev.wdt_timeout && !(pm_mode inside {PM_IDLE, PM_SLEEP}) |=> s_restart;
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("no restart on run timeout");
   property p_wdt_sleep;
      rst_ev.wdt_timeout && pm_mode inside {PM_IDLE, PM_SLEEP} |=> core.wake && !core.restart;
   endproperty
   a_wdt_sleep: assert property (p_wdt_sleep) else $error("timeout in sleep not a wake");
   property p_low;
      s_vector and core.pc_value == VEC_LOW |-> in_low && !in_high;
   endproperty
   a_low: assert property (p_low) else $error("low taken during high");
   property p_high;
      s_vector and core.pc_value == VEC_HIGH |-> in_high;
   endproperty
   a_high: assert property (p_high) else $error("high vector without high handler");
   property p_ret;
      handler_return && in_high |=> !in_high;
   endproperty
   a_ret: assert property (p_ret) else $error("return left handler running");
endmodule : pirc_ctrl_assertions
bind pirc_ctrl pirc_ctrl_assertions u_chk (.hclk, .hresetn, .pm_mode, .rst_ev, .handler_return, .core, .in_high,
   .in_low);

// ### pirc_pkg.sv
// Constants and carrier types for the prioritized interrupt and reset-cause controller.
// Assumes a single 200 MHz clock and an AHB-Lite register bus with word access only.
package pirc_pkg;

   // Source count and which sources sit behind the peripheral gate
   localparam int NSRC = 8;
   localparam logic [7:0] SRC_PERIPH_MASK = 8'hf8;

   // Vector addresses
   localparam logic [20:0] VEC_RESTART = 21'h000000;
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;

   // Register byte offsets
   localparam logic [7:0] OFS_IRQ_CTL = 8'h00;
   localparam logic [7:0] OFS_RCC = 8'h04;
   localparam logic [7:0] OFS_FLAG = 8'h08;
   localparam logic [7:0] OFS_EN = 8'h0c;
   localparam logic [7:0] OFS_PRI = 8'h10;
   localparam logic [7:0] OFS_STK = 8'h14;

   // Field positions
   localparam int CTL_HIGH_GE = 7;
   localparam int CTL_LOW_GE = 6;
   localparam int RCC_PRIO_EN = 7;
   localparam int RCC_SOFT_RST = 4;
   localparam int RCC_WDT_TO = 3;
   localparam int RCC_SLEEP = 2;
   localparam int RCC_POR = 1;
   localparam int RCC_BROWNOUT = 0;
   localparam int STK_OVF = 0;
   localparam int STK_UNF = 1;
   localparam int STK_RST_EN = 2;

   // Reset values and writable masks
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] CTL_WMASK = 8'hc0;
   localparam logic [7:0] RCC_RST = 8'h1c;
   localparam logic [7:0] RCC_WMASK = 8'h93;
   localparam logic [2:0] STK_RST = 3'h4;

   // Event to vector latency in cycles
   localparam int IRQ_LATENCY_CYC = 3;

   typedef enum logic [1:0] {PM_FULL_RUN, PM_LP_RUN, PM_IDLE, PM_SLEEP} pirc_pm_e;

   typedef struct packed {
      logic master_clear_input;
      logic wdt_timeout;
      logic stack_overflow;
      logic stack_underflow;
      logic reset_instr;
      logic brownout;
      logic sleep_instr;
   } pirc_rst_ev_s;

   typedef struct packed {
      logic pc_load;
      logic [20:0] pc_value;
      logic stack_push;
      logic wake;
      logic restart;
   } pirc_core_s;

endpackage : pirc_pkg

// ### tb_top.sv
// Self-checking bench for the interrupt and reset-cause controller.
// Assumes zero-wait AHB-Lite slave and the core model beside it.
`timescale 1ns/100ps
module tb_top
   import pirc_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ret_req = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [7:0] src_event = '0;
   logic hreadyout, hresp, handler_return, in_high, in_low;
   pirc_pm_e pm_mode = PM_FULL_RUN;
   pirc_rst_ev_s rst_ev = '0;
   pirc_core_s core;
   int miscompares = 0, checked = 0, n;
   // Register model; unmapped slots stay zero
   logic [7:0] m [8];
   logic [7:0] wm [8] = '{CTL_WMASK, RCC_WMASK, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00};
   always #2.5 hclk = ~hclk;
   pirc_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
      .hreadyout, .hresp, .src_event, .pm_mode, .rst_ev, .handler_return, .core, .in_high, .in_low);
   pirc_core_model u_core (.hclk, .hresetn, .core, .ret_req, .handler_return);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done;
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   task automatic hwait;
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 20) begin
            chk(0, 1, "hready");
            test_done();
         end
         @(posedge hclk);
      end
   endtask : hwait
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hwait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hwait();
      r = hrdata;
      if (w)
         m[a[4:2]] = (m[a[4:2]] & ~wm[a[4:2]]) | (d[7:0] & wm[a[4:2]]);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
      chk(r, {24'h0, m[a[4:2]]}, $sformatf("reg %h", a));
      chk(hresp, 1'b0, "hresp");
   endtask : rd
   task automatic wl;
      n = 1;
      while (core.pc_load !== 1'b1 && n < 9) begin
         @(posedge hclk);
         #1;
         n++;
      end
   endtask : wl
   task automatic ev(input int s);
      @(posedge hclk);
      src_event <= 8'h01 << s;
      @(posedge hclk);
      src_event <= 8'h00;
      wl();
   endtask : ev
   task automatic ret;
      @(posedge hclk);
      ret_req <= 1'b1;
      @(posedge hclk);
      ret_req <= 1'b0;
   endtask : ret
   task automatic rev(input logic [6:0] e, input pirc_pm_e pm, input logic rs, input logic wk);
      @(posedge hclk);
      rst_ev <= e;
      pm_mode <= pm;
      @(posedge hclk);
      rst_ev <= '0;
      #1;
      chk(core.restart, rs, "restart");
      chk(core.wake, wk, "wake");
      if (rs)
         chk(core.pc_value, VEC_RESTART, "restart pc");
      rd(OFS_RCC);
   endtask : rev
   initial begin
      m = '{CTL_RST, RCC_RST, 8'h00, 8'h00, 8'h00, {5'h0, STK_RST}, 8'h00, 8'h00};
      void'($urandom(32'he8f4b8f1));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a < 32; a += 4)
         rd(a[7:0]);
      wr(OFS_EN, $urandom());
      wr(OFS_PRI, $urandom());
      rd(OFS_EN);
      rd(OFS_PRI);
      // Compatibility mode; random priority bits must not matter
      wr(OFS_EN, 32'h0);
      wr(OFS_IRQ_CTL, 32'h80);
      ev(0);
      chk(n, 9, "vector while disabled");
      m[2] = 8'h01;
      rd(OFS_FLAG);
      wr(OFS_FLAG, 32'h0);
      wr(OFS_EN, 32'h09);
      ev(0);
      chk(n, IRQ_LATENCY_CYC, "latency");
      chk(core.pc_value, VEC_HIGH, "compat vector");
      chk(core.stack_push, 1'b1, "push");
      m[0] = 8'h00;
      rd(OFS_IRQ_CTL);
      wr(OFS_FLAG, 32'h0);
      ret();
      m[0] = 8'h80;
      rd(OFS_IRQ_CTL);
      ev(3);
      chk(n, 9, "peripheral gated");
      wr(OFS_IRQ_CTL, 32'hc0);
      wl();
      chk({core.pc_load, core.pc_value}, {1'b1, VEC_HIGH}, "peripheral vector");
      wr(OFS_FLAG, 32'h0);
      ret();
      // Priority levels: source 1 low, source 2 high
      wr(OFS_RCC, 32'h80);
      wr(OFS_PRI, 32'h04);
      wr(OFS_EN, 32'h06);
      wr(OFS_IRQ_CTL, 32'hc0);
      ev(1);
      chk({core.pc_value, in_low}, {VEC_LOW, 1'b1}, "low vector");
      m[0] = 8'h80;
      rd(OFS_IRQ_CTL);
      ev(2);
      chk({core.pc_value, in_high}, {VEC_HIGH, 1'b1}, "preempt");
      wr(OFS_FLAG, 32'h0);
      wr(OFS_IRQ_CTL, 32'hc0);
      ev(1);
      chk(n, 9, "low during high");
      ret();
      wl();
      chk(core.pc_value, VEC_LOW, "low after high");
      // Flags cleared first, or the low request would recur on return
      wr(OFS_FLAG, 32'h0);
      ret();
      // Reset causes; priority bit cleared first so the wake check below runs in compatibility mode
      wr(OFS_RCC, 32'h0);
      m[1][3:2] = 2'b10;
      rev(7'h40, PM_IDLE, 1'b1, 1'b0);
      m[1][3] = 1'b0;
      rev(7'h20, PM_FULL_RUN, 1'b1, 1'b0);
      m[1][3] = 1'b1;
      rev(7'h40, PM_LP_RUN, 1'b1, 1'b0);
      m[1][3] = 1'b0;
      rev(7'h20, PM_SLEEP, 1'b0, 1'b1);
      m[1][3] = 1'b1;
      rev(7'h01, PM_FULL_RUN, 1'b0, 1'b0);
      m[5][0] = 1'b1;
      rev(7'h10, PM_FULL_RUN, 1'b1, 1'b0);
      rd(OFS_STK);
      wr(OFS_STK, 32'h0);
      m[5][1] = 1'b1;
      rev(7'h08, PM_FULL_RUN, 1'b0, 1'b0);
      rd(OFS_STK);
      m[1][4:2] = 3'b111;
      rev(7'h02, PM_SLEEP, 1'b1, 1'b0);
      // Interrupt wake from sleep; global enable still set, so it vectors too
      m[1][2] = 1'b0;
      ev(1);
      chk({core.wake, core.pc_load, core.pc_value}, {2'b11, VEC_HIGH}, "wake vector");
      rd(OFS_RCC);
      m[1][4] = 1'b0;
      rev(7'h04, PM_FULL_RUN, 1'b1, 1'b0);
      test_done();
   end
endmodule : tb_top
